//--- hw/pad_decoder.sv
`timescale 1ns/1ps
// Operation
// RULE1 - area chosen from address bits 28 to 26, codes 000 to 111
// RULE2 - bits 31 to 29 ignored, so shadows alias the same area
// RULE3 - areas 0 to 4 each span 64 Mbytes, area 0 from zero
// RULE4 - area 0 select goes low during area 0 accesses
// RULE5 - each external area select goes low for its own area
// RULE6 - card mode in areas 5/6 adds per-byte card enables
// RULE7 - six direct select outputs: areas 0 and 2 to 6
// RULE8 - strap pins at reset fix area 0 width: 01=8,10=16,11=32
// RULE9 - areas 2 to 6 take width from per-area config field
// RULE10 - software uses only 16/32 bit width for sdram areas
// RULE11 - software uses only 8/16 bit width for card areas
// RULE12 - software gives areas 2 and 3 equal width when both sdram
// RULE13 - with ports A or B in use, all areas 8 or 16 bit; the decoder has no port input, and areas 1 and 7 always report 32 bit
// RULE14 - area 1 decodes to internal i/o, no external select
// RULE15 - software reaches area 1 untranslated via the 101 segment
// RULE16 - area 7 decodes as on-chip i/o space
// RULE17 - masters never access area 7 or its shadows
// RULE18 - areas 5/6 split: lower half memory, upper half i/o card
// RULE19 - logical space in five regions, physical in eight areas
// RULE20 - upper half of card areas runs i/o space card cycles
// RULE21 - all selects and enables negated outside their access
// RULE22 - area 0 width held until the next reset
module pad_decoder
    import pad_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic access_valid_i,
    input wire logic [ADDR_W-1:0] phys_addr_i,
    input wire logic [3:0] byte_enable_i,
    input wire logic [ADDR_W-1:0] logical_addr_i,
    input wire logic width_strap_hi_i,
    input wire logic width_strap_lo_i,
    input wire logic [CFG_W-1:0] area_width_config_i,
    input wire logic card_mode_area5_i,
    input wire logic card_mode_area6_i,
    output logic area0_select_n_o,
    output logic area2_select_n_o,
    output logic area3_select_n_o,
    output logic area4_select_n_o,
    output logic area5_select_n_o,
    output logic area6_select_n_o,
    output logic card_a_low_byte_enable_n_o,
    output logic card_a_high_byte_enable_n_o,
    output logic card_b_low_byte_enable_n_o,
    output logic card_b_high_byte_enable_n_o,
    output logic card_io_cycle_o,
    output logic internal_io_select_o,
    output logic onchip_io_select_o,
    output logic [1:0] bus_width_o,
    output logic [2:0] logical_region_o,
    output logic [2:0] area_code_o,
    output logic strap_reserved_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // only bits 28..26 matter; upper bits alias into shadows
    function automatic logic [2:0] area_of(input logic [ADDR_W-1:0] a);
        area_of = a[AREA_HI:AREA_LO]; // RULE1 RULE2 RULE3
    endfunction : area_of

    function automatic logic [1:0] cfg_width(input logic [CFG_W-1:0] c,
                                             input logic [2:0] area);
        logic [2:0] idx;
        idx = area - AREA2;
        cfg_width = c[{idx, 1'b0} +: 2];
    endfunction : cfg_width

    // five logical regions: the four lower 512M blocks merged as region 0
    function automatic logic [2:0] region_of(input logic [2:0] top);
        region_of = top[2] ? {1'b0, top[1:0]} + 3'h1 : 3'h0;
    endfunction : region_of

    // 16-bit card: even lanes on the low strobe, odd lanes on the high
    function automatic logic [1:0] lanes_n(input logic [3:0] be);
        lanes_n = ~{be[3] | be[1], be[2] | be[0]};
    endfunction : lanes_n

    typedef struct packed {
        logic [6:0] sel_n;
        logic [3:0] card_en_n;
        logic card_io;
        logic int_io;
        logic chip_io;
        logic [1:0] width;
        logic [2:0] region;
        logic [2:0] area;
        logic strap_bad;
    } pad_dec_t;
    pad_dec_t st;
    pad_dec_t next_st;

    logic [1:0] area0_width;

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    pad_strap i_pad_strap (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .width_strap_hi_i(width_strap_hi_i),
        .width_strap_lo_i(width_strap_lo_i),
        .area0_width_o(area0_width)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // outputs registered, so strobes trail the request by one cycle
    always_comb begin
        logic [2:0] a;
        logic card;
        a = area_of(phys_addr_i);
        card = 1'b0;
        next_st = '{sel_n: SEL_IDLE, card_en_n: 4'hF, card_io: 1'b0,
                    int_io: 1'b0, chip_io: 1'b0, width: st.width,
                    region: region_of(logical_addr_i[31:29]),
                    area: a, strap_bad: (area0_width == WID_RSVD)}; // RULE19
        if (access_valid_i) begin // RULE21
            unique case (a)
                AREA0: begin
                    next_st.sel_n[0] = 1'b0; // RULE4 RULE7
                    next_st.width = area0_width; // RULE8
                end
                AREA1: begin
                    next_st.int_io = 1'b1; // RULE14
                    next_st.width = WID_32;
                end
                AREA7: begin
                    next_st.chip_io = 1'b1; // RULE16 RULE17
                    next_st.width = WID_32;
                end
                default: begin
                    next_st.sel_n[a] = 1'b0; // RULE5 RULE7
                    next_st.width = cfg_width(area_width_config_i, a); // RULE9
                end
            endcase
            card = (a == AREA5 && card_mode_area5_i) ||
                   (a == AREA6 && card_mode_area6_i);
            if (card) begin
                // low/high byte enables from the bytes in flight
                next_st.card_en_n[1:0] = (a == AREA5) ?
                    lanes_n(byte_enable_i) : 2'h3; // RULE6
                next_st.card_en_n[3:2] = (a == AREA6) ?
                    lanes_n(byte_enable_i) : 2'h3; // RULE6
                next_st.card_io = phys_addr_i[HALF_BIT]; // RULE18 RULE20
            end
        end
    end

    // synchronous reset, every select negated
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st <= '{sel_n: SEL_IDLE, card_en_n: 4'hF, card_io: 1'b0,
                    int_io: 1'b0, chip_io: 1'b0, width: WID_32,
                    region: 3'h0, area: 3'h0, strap_bad: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign area0_select_n_o = st.sel_n[0];
    assign area2_select_n_o = st.sel_n[2];
    assign area3_select_n_o = st.sel_n[3];
    assign area4_select_n_o = st.sel_n[4];
    assign area5_select_n_o = st.sel_n[5];
    assign area6_select_n_o = st.sel_n[6];
    assign card_a_low_byte_enable_n_o = st.card_en_n[0];
    assign card_a_high_byte_enable_n_o = st.card_en_n[1];
    assign card_b_low_byte_enable_n_o = st.card_en_n[2];
    assign card_b_high_byte_enable_n_o = st.card_en_n[3];
    assign card_io_cycle_o = st.card_io;
    assign internal_io_select_o = st.int_io;
    assign onchip_io_select_o = st.chip_io;
    assign bus_width_o = st.width;
    assign logical_region_o = st.region;
    assign area_code_o = st.area;
    assign strap_reserved_o = st.strap_bad;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_area0_sel: assert property (@(posedge sys_clk_i) // RULE4
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h0 |=> !area0_select_n_o)
        else $error("area 0 select missing");
    chk_area6_sel: assert property (@(posedge sys_clk_i) // RULE5
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h6
        |=> !area6_select_n_o && area5_select_n_o)
        else $error("area 6 select wrong");
    chk_idle_negate: assert property (@(posedge sys_clk_i) // RULE21
        disable iff (!rst_b_i)
        !access_valid_i |=> st.sel_n == 7'h7F && st.card_en_n == 4'hF)
        else $error("select active while idle");
    chk_shadow_alias: assert property (@(posedge sys_clk_i) // RULE2
        disable iff (!rst_b_i)
        access_valid_i |=> area_code_o == $past(phys_addr_i[28:26]))
        else $error("area code ignores shadow rule");
    chk_area1_intern: assert property (@(posedge sys_clk_i) // RULE14
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h1
        |=> internal_io_select_o && st.sel_n == 7'h7F)
        else $error("area 1 drove external select");
    chk_area7_onchip: assert property (@(posedge sys_clk_i) // RULE16
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h7 |=> onchip_io_select_o)
        else $error("area 7 not on-chip");
    chk_card_enable: assert property (@(posedge sys_clk_i) // RULE6
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h5 && card_mode_area5_i
        && (byte_enable_i[0] || byte_enable_i[2])
        |=> !card_a_low_byte_enable_n_o && !area5_select_n_o)
        else $error("card enable missing");
    chk_card_lanes: assert property (@(posedge sys_clk_i) // RULE6
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h6 && card_mode_area6_i
        |=> card_b_high_byte_enable_n_o
            == !$past(byte_enable_i[1] || byte_enable_i[3]))
        else $error("card high lane enable wrong");
    chk_card_iohalf: assert property (@(posedge sys_clk_i) // RULE20
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h6 && card_mode_area6_i
        |=> card_io_cycle_o == $past(phys_addr_i[25]))
        else $error("card i/o half wrong");
    chk_cfg_width: assert property (@(posedge sys_clk_i) // RULE9
        disable iff (!rst_b_i)
        access_valid_i && phys_addr_i[28:26] == 3'h4
        |=> bus_width_o == $past(area_width_config_i[5:4]))
        else $error("area 4 width wrong");
    cov_area0: cover property (@(posedge sys_clk_i) !area0_select_n_o);
    cov_card_io: cover property (@(posedge sys_clk_i) card_io_cycle_o);
    cov_onchip: cover property (@(posedge sys_clk_i) onchip_io_select_o);
endmodule : pad_decoder

//--- hw/pad_pkg.sv
package pad_pkg;
    // ------------------------------------------------------------------
    // area decode
    // ------------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int AREA_HI = 28;
    localparam int AREA_LO = 26;
    localparam int HALF_BIT = 25; // upper half of areas 5 and 6 is i/o
    localparam logic [2:0] AREA0 = 3'h0;
    localparam logic [2:0] AREA1 = 3'h1;
    localparam logic [2:0] AREA2 = 3'h2;
    localparam logic [2:0] AREA3 = 3'h3;
    localparam logic [2:0] AREA4 = 3'h4;
    localparam logic [2:0] AREA5 = 3'h5;
    localparam logic [2:0] AREA6 = 3'h6;
    localparam logic [2:0] AREA7 = 3'h7;
    localparam int NUM_SEL = 7; // index 1 unused, areas 0,2..6 drive pins
    // ------------------------------------------------------------------
    // bus width codes
    // ------------------------------------------------------------------
    localparam logic [1:0] WID_RSVD = 2'h0;
    localparam logic [1:0] WID_8 = 2'h1;
    localparam logic [1:0] WID_16 = 2'h2;
    localparam logic [1:0] WID_32 = 2'h3;
    localparam logic [1:0] STRAP_RST = 2'h3;
    localparam int CFG_W = 10; // two bits per area 2..6
    localparam logic [6:0] SEL_IDLE = 7'h7F;
    localparam logic [3:0] BE_NONE = 4'h0;
endpackage : pad_pkg

//--- hw/pad_strap.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// power-on strap capture
// ----------------------------------------------------------------------
module pad_strap
    import pad_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic width_strap_hi_i,
    input wire logic width_strap_lo_i,
    output logic [1:0] area0_width_o
);
    typedef struct packed {
        logic in_reset;
        logic [1:0] width;
    } pad_strap_t;
    pad_strap_t st;
    pad_strap_t next_st;

    // capture on the first clock after release, held until next reset
    always_comb begin
        next_st = st;
        next_st.in_reset = 1'b0;
        if (st.in_reset) begin
            next_st.width = {width_strap_hi_i, width_strap_lo_i}; // RULE8
        end
    end

    // synchronous reset loads constants only, pins sampled afterwards
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st <= '{in_reset: 1'b1, width: STRAP_RST};
        end else begin
            st <= next_st; // RULE22
        end
    end

    assign area0_width_o = st.width;

    chk_strap_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE22
        !st.in_reset && !$past(st.in_reset) |-> $stable(area0_width_o))
        else $error("area 0 width changed after capture");
endmodule : pad_strap

//--- verification/pad_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// external memory side: watches the six select pins
// ----------------------------------------------------------------------
module pad_mem_model (
    input wire logic sys_clk_i,
    input wire logic [5:0] select_n_i,
    output logic multi_select_o
);
    // two devices driving the data bus at once would be a short
    always_ff @(posedge sys_clk_i) begin
        multi_select_o <= ($countones(~select_n_i) > 1);
    end
endmodule : pad_mem_model

//--- verification/pad_decoder_bench.sv
`timescale 1ns/1ps
module pad_decoder_bench;
    import pad_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic valid = 1'b0;
    logic [31:0] phys = 32'h0;
    logic [3:0] be = 4'h0;
    logic shi = 1'b0;
    logic slo = 1'b1;
    logic c5 = 1'b1;
    logic c6 = 1'b1;
    // no sdram and no ports A/B in use; card areas 5 and 6 at 8 and 16
    logic [9:0] cfg = 10'h279;
    logic [31:0] laddr = 32'hA0000000;
    logic [3:0] be_req = 4'h4; // lanes asked for by the next access
    logic [1:0] w0 = WID_8; // area 0 width from the straps at release
    logic s0, s2, s3, s4, s5, s6, cal, cah, cbl, cbh, cio, iio, oio, srsv;
    logic multi;
    logic [1:0] bw;
    logic [2:0] region, ac;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    wire logic [9:0] pins = {s0, s2, s3, s4, s5, s6, cal, cah, cbl, cbh};
    // ------------------------------------------------------------------
    // clock and instances
    // ------------------------------------------------------------------
    always #20 sys_clk_i = ~sys_clk_i;
    pad_decoder i_pad_decoder (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .access_valid_i(valid), .phys_addr_i(phys), .byte_enable_i(be),
        .logical_addr_i(laddr), .width_strap_hi_i(shi),
        .width_strap_lo_i(slo), .area_width_config_i(cfg),
        .card_mode_area5_i(c5), .card_mode_area6_i(c6),
        .area0_select_n_o(s0), .area2_select_n_o(s2),
        .area3_select_n_o(s3), .area4_select_n_o(s4),
        .area5_select_n_o(s5), .area6_select_n_o(s6),
        .card_a_low_byte_enable_n_o(cal), .card_a_high_byte_enable_n_o(cah),
        .card_b_low_byte_enable_n_o(cbl), .card_b_high_byte_enable_n_o(cbh),
        .card_io_cycle_o(cio), .internal_io_select_o(iio),
        .onchip_io_select_o(oio), .bus_width_o(bw),
        .logical_region_o(region), .area_code_o(ac),
        .strap_reserved_o(srsv));
    pad_mem_model i_pad_mem_model (.sys_clk_i(sys_clk_i),
        .select_n_i({s0, s2, s3, s4, s5, s6}), .multi_select_o(multi));
    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    task chk_pins(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: pins %h not %h", $time, got, exp);
        end
    endtask : chk_pins
    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: field %h not %h", $time, got, exp);
        end
    endtask : chk_val
    // hang guard: the whole run needs well under 100 cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            $display("wrong value at %0t: run did not finish", $time);
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // one access, entered at a falling edge; area a in shadow 6-a
    // ------------------------------------------------------------------
    task run(input int a, input logic v);
        logic [31:0] ad;
        logic [9:0] e;
        logic [1:0] w;
        logic io;
        logic m;
        ad = {3'(6 - a), 3'(a), 1'(a % 2), 25'h0};
        valid = v;
        phys = ad;
        be = be_req;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        m = (a == 5) ? c5 : c6;
        io = v && a >= 5 && ad[HALF_BIT] && m;
        // card strobes pair even lanes low, odd lanes high
        e = {!(v && a == 0), !(v && a == 2), !(v && a == 3), !(v && a == 4),
            !(v && a == 5), !(v && a == 6),
            !(v && a == 5 && c5 && (be_req[0] || be_req[2])),
            !(v && a == 5 && c5 && (be_req[1] || be_req[3])),
            !(v && a == 6 && c6 && (be_req[0] || be_req[2])),
            !(v && a == 6 && c6 && (be_req[1] || be_req[3]))};
        if (a == 0) w = w0;
        else if (a == 1) w = 2'h3;
        else w = cfg[2 * (a - 2) +: 2];
        chk_pins(pins, e);
        chk_val({cio, iio, oio, 2'h0, ac}, {io, v && a == 1, 3'h0, 3'(a)});
        chk_val({7'h0, multi}, 8'h0);
        if (v) chk_val({6'h0, bw}, {6'h0, w});
    endtask : run
    // logical region follows the top address bits one cycle later
    task region_at(input logic [31:0] la, input logic [2:0] exp);
        laddr = la;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_val({5'h0, region}, {5'h0, exp});
    endtask : region_at
    // reset in mid-run, straps set while held; returns after capture
    task reset_with(input logic hi, input logic lo);
        valid = 1'b0;
        rst_b_i = 1'b0;
        shi = hi;
        slo = lo;
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_pins(pins, 10'h3FF);
        rst_b_i = 1'b1;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : reset_with
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        shi = 1'b1; // late strap change must not move area 0 width
        slo = 1'b0;
        // area 7 is left alone: masters may not touch it or its shadows
        for (int a = 0; a < 7; a++) run(a, 1'b1);
        be_req = 4'h2; // odd lane only: low strobe must stay off
        run(5, 1'b1);
        run(6, 1'b1);
        be_req = 4'h4;
        c5 = 1'b0;
        run(5, 1'b1);
        c6 = 1'b0;
        run(6, 1'b1);
        run(2, 1'b0);
        chk_val({4'h0, srsv, region}, 8'h02);
        region_at(32'h60000000, 3'h0);
        region_at(32'h80000000, 3'h1);
        region_at(32'hE0000000, 3'h4);
        // second reset with reserved straps: flag shows a cycle later
        reset_with(1'b0, 1'b0);
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_val({7'h0, srsv}, 8'h01);
        // third reset with 16-bit straps, moved again after capture
        reset_with(1'b1, 1'b0);
        shi = 1'b0;
        slo = 1'b1;
        w0 = WID_16;
        run(0, 1'b1);
        summarize();
    end
endmodule : pad_decoder_bench
